/* File: include/dtmf_host_defs.vh */
// Behaviour
// - Select line and read/write pick transmit write, receive read, control write, status read.
// - Receive code register holds the last validly decoded four-bit tone code, read only.
// - Transmit code register is write only and selects the generated tone pair.
// - Set bank select bit steers the next control write to the second register.
// - First control: b3 bank select, b2 interrupt enable, b1 progress mode, b0 tone enable.
// - Second control: b3 column/row, b2 single/dual, b1 test, b0 burst control.
// - Request pin signals validated receive, or transmitter ready in burst mode only.
// - Request pin is open drain: pulls low only, released otherwise.
// - Status b2 set by valid received data, cleared by a status read.
// - New-data interrupt is cleared by a status read.
// - Tone too short to validate leaves the receive code untouched; valid tone latches.
// - After validated tone end the receive code is kept until the next tone.
// - Dropout shorter than absence guard leaves data and steering state unchanged.
// - Delayed steering changes only after guard times; active low during valid signal.
// - All timing derives from a 3.579545 MHz reference; here only the tones do, guard and burst times count the 40 MHz clock.
// - Single-tone mode generates one tone from low or high group.
// - Tones land on 699.1, 766.2, 847.4, 948.0, 1215.9, 1331.7, 1471.9, 1645.0 Hz.
// - Tone enable bit at one enables tone output, burst or not.
// - Progress mode at one disables tone decoding; zero selects tone operation.
// - Interrupt enable plus tone mode pulls request pin low on its events.
// - Burst and pause last 51 ms, 102 ms in progress mode, then ready is set.
`ifndef DTMF_HOST_DEFS_VH
`define DTMF_HOST_DEFS_VH

// Register select values
`define SEL_DATA          1'b0
`define SEL_CONTROL       1'b1

// First control register fields
`define C1_TONE_EN        0
`define C1_PROGRESS       1
`define C1_IRQ_EN         2
`define C1_BANK_SEL       3

// Second control register fields
`define C2_BURST_N        0
`define C2_TEST           1
`define C2_SINGLE         2
`define C2_COLUMN         3

// Status register fields
`define ST_IRQ            0
`define ST_TX_READY       1
`define ST_RX_VALID       2
`define ST_STEER          3

// Reset values
`define CTRL_RESET        4'h0
`define CODE_RESET        4'h0

// Clock and reference rates
`define CLK_HZ            40000000
`define CLK_KHZ           40000
`define REF_HZ            3579545

// Times in ms and cycle counts derived from them
`define GUARD_PRESENT_MS  40
`define GUARD_ABSENT_MS   40
`define BURST_MS          51
`define GUARD_PRESENT_CYC (`GUARD_PRESENT_MS * `CLK_KHZ)
`define GUARD_ABSENT_CYC  (`GUARD_ABSENT_MS * `CLK_KHZ)
`define BURST_CYC         (`BURST_MS * `CLK_KHZ)

// Reference divider values per tone, 32 segments per tone period
`define DIV_L1            8'hA0
`define DIV_L2            8'h92
`define DIV_L3            8'h84
`define DIV_L4            8'h76
`define DIV_H1            8'h5C
`define DIV_H2            8'h54
`define DIV_H3            8'h4C
`define DIV_H4            8'h44

`endif

/* File: rtl/dtmf_transceiver_host_registers.v */
`timescale 1ns/10ps
`include "dtmf_host_defs.vh"

module dtmf_transceiver_host_registers #(
   parameter [21:0] GUARD_PRESENT_CYC = `GUARD_PRESENT_CYC,
   parameter [21:0] GUARD_ABSENT_CYC  = `GUARD_ABSENT_CYC,
   parameter [21:0] BURST_CYC         = `BURST_CYC
) (
   // Clock, reset, enable
   input  wire       clk_i,
   input  wire       rstn_i,
   input  wire       ce_i,
   // Host bus
   input  wire       chip_select_n_i,
   input  wire       register_select_line_i,
   input  wire       read_write_i,
   input  wire       access_strobe_i,
   input  wire [3:0] data_i,
   output reg  [3:0] data_q_o,
   output wire       data_oe_n_o,
   // Receiver front end
   input  wire       tone_present_i,
   input  wire [3:0] decoded_code_i,
   input  wire       progress_square_i,
   output wire       early_detect_out_o,
   output wire       delayed_steer_n_o,
   output wire [3:0] received_code_bits_o,
   // Request pin, open drain
   output wire       request_or_progress_pin_o,
   output wire       request_or_progress_pin_oe_n_o,
   // Transmitter
   output wire       tone_output_enable_o,
   output reg        tone_low_on_o,
   output reg        tone_high_on_o,
   output reg  [4:0] tone_low_phase_o,
   output reg  [4:0] tone_high_phase_o
);

   // Transmit sequencer states, one-hot
   localparam [2:0] TX_IDLE  = 3'b001;
   localparam [2:0] TX_BURST = 3'b010;
   localparam [2:0] TX_PAUSE = 3'b100;

   localparam [25:0] REF_STEP = `REF_HZ;
   localparam [25:0] CLK_WRAP = `CLK_HZ;

   // Row index of a tone code
   function [1:0] row_of;
      input [3:0] code;
      begin
         case (code)
            4'h1, 4'h2, 4'h3, 4'hD: row_of = 2'h0;
            4'h4, 4'h5, 4'h6, 4'hE: row_of = 2'h1;
            4'h7, 4'h8, 4'h9, 4'hF: row_of = 2'h2;
            default:                row_of = 2'h3;
         endcase
      end
   endfunction

   // Column index of a tone code
   function [1:0] col_of;
      input [3:0] code;
      begin
         case (code)
            4'h1, 4'h4, 4'h7, 4'hB: col_of = 2'h0;
            4'h2, 4'h5, 4'h8, 4'hA: col_of = 2'h1;
            4'h3, 4'h6, 4'h9, 4'hC: col_of = 2'h2;
            default:                col_of = 2'h3;
         endcase
      end
   endfunction

   // Reference ticks per phase segment for a group and index
   function [7:0] seg_div;
      input       high;
      input [1:0] idx;
      begin
         case ({high, idx})
            3'h0:    seg_div = `DIV_L1;
            3'h1:    seg_div = `DIV_L2;
            3'h2:    seg_div = `DIV_L3;
            3'h3:    seg_div = `DIV_L4;
            3'h4:    seg_div = `DIV_H1;
            3'h5:    seg_div = `DIV_H2;
            3'h6:    seg_div = `DIV_H3;
            default: seg_div = `DIV_H4;
         endcase
      end
   endfunction

   reg  [3:0]  tx_code_q;
   reg  [3:0]  rx_code_q;
   reg  [3:0]  ctrl1_q;
   reg  [3:0]  ctrl2_q;
   reg         to_second_q;
   reg         rx_valid_q;
   reg         irq_q;
   reg         tx_ready_q;
   reg         steer_q;
   reg  [21:0] guard_cnt_q;
   reg  [2:0]  tx_state_q;
   reg  [21:0] burst_cnt_q;
   reg         tx_start_q;
   reg  [25:0] ref_acc_q;
   reg         ref_tick_q;
   reg  [7:0]  low_div_q;
   reg  [7:0]  high_div_q;

   // Bus decode, only while selected
   wire acc      = ce_i & ~chip_select_n_i & access_strobe_i;
   wire wr_tx    = acc & ~read_write_i & (register_select_line_i == `SEL_DATA);
   wire rd_rx    = acc &  read_write_i & (register_select_line_i == `SEL_DATA);
   wire wr_ctrl  = acc & ~read_write_i & (register_select_line_i == `SEL_CONTROL);
   wire rd_stat  = acc &  read_write_i & (register_select_line_i == `SEL_CONTROL);

   wire progress = ctrl1_q[`C1_PROGRESS];
   wire burst_on = ~ctrl2_q[`C2_BURST_N];
   wire [3:0] status = {steer_q, rx_valid_q, tx_ready_q, irq_q};

   // Data lines driven while a read is addressed
   assign data_oe_n_o = ~(~chip_select_n_i & read_write_i);

   // Register writes and control pointer
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_code_q   <= `CODE_RESET;
         ctrl1_q     <= `CTRL_RESET;
         ctrl2_q     <= `CTRL_RESET;
         to_second_q <= 1'b0;
         tx_start_q  <= 1'b0;
      end else if (ce_i) begin
         tx_start_q <= wr_tx;
         if (wr_tx) begin
            tx_code_q <= data_i;
         end
         if (wr_ctrl) begin
            if (to_second_q) begin
               ctrl2_q     <= data_i;
               to_second_q <= 1'b0;
            end else begin
               ctrl1_q     <= data_i;
               to_second_q <= data_i[`C1_BANK_SEL];
            end
         end
      end
   end

   // Read data captured at the strobe edge
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_q_o <= 4'h0;
      end else if (ce_i) begin
         if (rd_rx) begin
            data_q_o <= rx_code_q;
         end else if (rd_stat) begin
            data_q_o <= status;
         end
      end
   end

   // Early detection is masked in progress mode, so no decoding happens there
   assign early_detect_out_o = tone_present_i & ~progress;

   // Guard timing: a presence or absence must persist a full guard time
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         steer_q     <= 1'b0;
         guard_cnt_q <= 22'h000000;
         rx_code_q   <= `CODE_RESET;
      end else if (ce_i) begin
         if (early_detect_out_o == steer_q) begin
            guard_cnt_q <= 22'h000000; // Short burst or dropout discarded
         end else if (!steer_q && guard_cnt_q >= GUARD_PRESENT_CYC - 22'h000001) begin
            steer_q     <= 1'b1;
            guard_cnt_q <= 22'h000000;
            rx_code_q   <= decoded_code_i;
         end else if (steer_q && guard_cnt_q >= GUARD_ABSENT_CYC - 22'h000001) begin
            steer_q     <= 1'b0; // Code kept until next tone
            guard_cnt_q <= 22'h000000;
         end else begin
            guard_cnt_q <= guard_cnt_q + 22'h000001;
         end
      end
   end

   wire rx_event = ce_i & ~steer_q & (early_detect_out_o != steer_q) &
                   (guard_cnt_q >= GUARD_PRESENT_CYC - 22'h000001);

   assign delayed_steer_n_o    = ~steer_q;
   assign received_code_bits_o = rx_code_q;

   // Burst sequencer; progress mode doubles both intervals
   wire [21:0] burst_len = progress ? {BURST_CYC[20:0], 1'b0} : BURST_CYC;
   wire        burst_end = burst_cnt_q >= burst_len - 22'h000001;
   wire        tx_event  = ce_i & tx_state_q[2] & burst_end;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_state_q  <= TX_IDLE;
         burst_cnt_q <= 22'h000000;
      end else if (ce_i) begin
         case (tx_state_q)
            TX_IDLE: begin
               burst_cnt_q <= 22'h000000;
               if (tx_start_q && burst_on) begin
                  tx_state_q <= TX_BURST;
               end
            end
            TX_BURST: begin
               if (burst_end) begin
                  burst_cnt_q <= 22'h000000;
                  tx_state_q  <= TX_PAUSE;
               end else begin
                  burst_cnt_q <= burst_cnt_q + 22'h000001;
               end
            end
            TX_PAUSE: begin
               if (burst_end) begin
                  burst_cnt_q <= 22'h000000;
                  tx_state_q  <= TX_IDLE;
               end else begin
                  burst_cnt_q <= burst_cnt_q + 22'h000001;
               end
            end
            default: begin
               tx_state_q  <= TX_IDLE;
               burst_cnt_q <= 22'h000000;
            end
         endcase
      end
   end

   // Sticky flags; a new event in the clearing read cycle wins
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_valid_q <= 1'b0;
         irq_q      <= 1'b0;
         tx_ready_q <= 1'b0;
      end else if (ce_i) begin
         if (rx_event) begin
            rx_valid_q <= 1'b1;
         end else if (rd_stat) begin
            rx_valid_q <= 1'b0;
         end
         if (rx_event || (tx_event && burst_on)) begin
            irq_q <= 1'b1;
         end else if (rd_stat) begin
            irq_q <= 1'b0;
         end
         if (tx_event) begin
            tx_ready_q <= 1'b1;
         end else if (rd_stat) begin
            tx_ready_q <= 1'b0;
         end
      end
   end

   // Request pin: pulls low only, an external pull-up gives the high level
   reg pin_low;
   always @* begin
      pin_low = 1'b0;
      if (ctrl2_q[`C2_TEST] && !progress) begin
         pin_low = steer_q; // Presents delayed steering, inverted
      end else if (ctrl1_q[`C1_IRQ_EN]) begin
         if (progress) begin
            pin_low = ~progress_square_i;
         end else begin
            pin_low = (rx_valid_q & irq_q) | (tx_ready_q & irq_q & burst_on);
         end
      end
   end
   assign request_or_progress_pin_o      = 1'b0;
   assign request_or_progress_pin_oe_n_o = ~pin_low;

   // Tone enable and group gating
   assign tone_output_enable_o = ctrl1_q[`C1_TONE_EN];
   wire tone_run = tone_output_enable_o & (burst_on ? tx_state_q[1] : 1'b1);
   wire low_run  = tone_run & (~ctrl2_q[`C2_SINGLE] | ~ctrl2_q[`C2_COLUMN]);
   wire high_run = tone_run & (~ctrl2_q[`C2_SINGLE] |  ctrl2_q[`C2_COLUMN]);

   // Reference tick: fractional step from the system clock to 3.579545 MHz
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ref_acc_q  <= 26'h0000000;
         ref_tick_q <= 1'b0;
      end else if (ce_i) begin
         if (ref_acc_q + REF_STEP >= CLK_WRAP) begin
            ref_acc_q  <= ref_acc_q + REF_STEP - CLK_WRAP;
            ref_tick_q <= 1'b1;
         end else begin
            ref_acc_q  <= ref_acc_q + REF_STEP;
            ref_tick_q <= 1'b0;
         end
      end
   end

   // Segment dividers and 32-step phase counters per group
   wire [7:0] low_div  = seg_div(1'b0, row_of(tx_code_q));
   wire [7:0] high_div = seg_div(1'b1, col_of(tx_code_q));

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         low_div_q         <= 8'h00;
         high_div_q        <= 8'h00;
         tone_low_phase_o  <= 5'h00;
         tone_high_phase_o <= 5'h00;
         tone_low_on_o     <= 1'b0;
         tone_high_on_o    <= 1'b0;
      end else if (ce_i) begin
         tone_low_on_o  <= low_run;
         tone_high_on_o <= high_run;
         if (!low_run) begin
            low_div_q        <= 8'h00;
            tone_low_phase_o <= 5'h00;
         end else if (ref_tick_q) begin
            if (low_div_q >= low_div - 8'h01) begin
               low_div_q        <= 8'h00;
               tone_low_phase_o <= tone_low_phase_o + 5'h01;
            end else begin
               low_div_q <= low_div_q + 8'h01;
            end
         end
         if (!high_run) begin
            high_div_q        <= 8'h00;
            tone_high_phase_o <= 5'h00;
         end else if (ref_tick_q) begin
            if (high_div_q >= high_div - 8'h01) begin
               high_div_q        <= 8'h00;
               tone_high_phase_o <= tone_high_phase_o + 5'h01;
            end else begin
               high_div_q <= high_div_q + 8'h01;
            end
         end
      end
   end

endmodule

/* File: test/dtmf_host_chk.sv */
`timescale 1ns/10ps
module dtmf_host_chk #(
   parameter [21:0] GUARD_PRESENT_CYC = 22'h14,
   parameter [21:0] GUARD_ABSENT_CYC  = 22'h14,
   parameter [21:0] BURST_CYC         = 22'h32
) (
   // Clock and reset
   input wire       clk_i,
   input wire       rstn_i,
   // Host bus
   input wire       ce_i,
   input wire       chip_select_n_i,
   input wire       register_select_line_i,
   input wire       read_write_i,
   input wire       access_strobe_i,
   input wire [3:0] data_q_o,
   input wire       data_oe_n_o,
   // Receiver and transmitter
   input wire       tone_present_i,
   input wire       early_detect_out_o,
   input wire       delayed_steer_n_o,
   input wire [3:0] received_code_bits_o,
   input wire       request_or_progress_pin_o,
   input wire       tone_output_enable_o,
   input wire       tone_low_on_o,
   input wire       tone_high_on_o
);
   reg  [21:0] pres_q;
   reg  [21:0] abs_q;
   reg  [21:0] on_q;
   reg         rd_q;
   reg         cw_q;
   wire        take_w = ce_i && !chip_select_n_i && access_strobe_i;

   // Run lengths of presence, absence and tone output; taken accesses one edge late
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pres_q <= 22'h0;
         abs_q  <= 22'h0;
         on_q   <= 22'h0;
         rd_q   <= 1'b0;
         cw_q   <= 1'b0;
      end else begin
         pres_q <= tone_present_i ? pres_q + 22'h1 : 22'h0;
         abs_q  <= tone_present_i ? 22'h0 : abs_q + 22'h1;
         on_q   <= (tone_low_on_o || tone_high_on_o) ? on_q + 22'h1 : 22'h0;
         rd_q   <= take_w && read_write_i;
         cw_q   <= take_w && register_select_line_i && !read_write_i;
      end
   end

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Guard figures get one cycle of slack so a count that starts at zero or one both pass
   a_pin_drains_only: assert property (request_or_progress_pin_o == 1'b0)
      else $error("request pin data driven high");
   a_read_drive_window: assert property (data_oe_n_o == (chip_select_n_i || !read_write_i))
      else $error("data lines driven outside a selected read");
   a_read_data_cause: assert property (!$stable(data_q_o) |-> rd_q)
      else $error("read data changed without a read");
   a_control_write_cause: assert property (!$stable(tone_output_enable_o) |-> cw_q)
      else $error("tone enable changed without a control write");
   a_rx_code_latch: assert property (!$stable(received_code_bits_o) |-> $fell(delayed_steer_n_o))
      else $error("receive code changed outside a validation");
   a_steer_present_guard: assert property ($fell(delayed_steer_n_o) |-> pres_q >= GUARD_PRESENT_CYC - 22'h1)
      else $error("steering asserted before the presence guard");
   a_steer_absent_guard: assert property ($rose(delayed_steer_n_o) |-> abs_q >= GUARD_ABSENT_CYC - 22'h1)
      else $error("steering released before the absence guard");
   a_tone_gated: assert property ((tone_low_on_o || tone_high_on_o) |-> tone_output_enable_o || $past(tone_output_enable_o))
      else $error("tone running with output disabled");
   a_steer_holds: assert property ($fell(delayed_steer_n_o) |-> !delayed_steer_n_o [*3])
      else $error("steering pulse too short");
   a_early_needs_tone: assert property (early_detect_out_o |-> tone_present_i)
      else $error("early detect without tone");

   c_valid_tone: cover property ($fell(delayed_steer_n_o));
   c_control_write: cover property (cw_q);
   c_full_burst: cover property (on_q == BURST_CYC);
endmodule

bind dtmf_transceiver_host_registers dtmf_host_chk #(
   .GUARD_PRESENT_CYC(GUARD_PRESENT_CYC),
   .GUARD_ABSENT_CYC (GUARD_ABSENT_CYC),
   .BURST_CYC        (BURST_CYC)
) chk (
   .clk_i, .rstn_i, .ce_i, .chip_select_n_i, .register_select_line_i, .read_write_i, .access_strobe_i,
   .data_q_o, .data_oe_n_o, .tone_present_i, .early_detect_out_o, .delayed_steer_n_o, .received_code_bits_o,
   .request_or_progress_pin_o, .tone_output_enable_o, .tone_low_on_o, .tone_high_on_o
);

/* File: test/host_cpu_model.sv */
`timescale 1ns/10ps
module host_cpu_model (
   // Clock
   input  wire       clk_i,
   // Bus towards the device
   output reg        chip_select_n_o,
   output reg        register_select_line_o,
   output reg        read_write_o,
   output reg        access_strobe_o,
   output reg  [3:0] data_o,
   input  wire [3:0] data_i
);
   reg [3:0] rdata_q;

   // Idle bus: deselected, no strobe
   initial begin
      chip_select_n_o        = 1'b1;
      register_select_line_o = 1'b0;
      read_write_o           = 1'b1;
      access_strobe_o        = 1'b0;
      data_o                 = 4'h0;
      rdata_q                = 4'h0;
   end

   // One access; stale write data is inverted so it never passes as the last value
   task acc(input sel_n, input rs, input rw, input [3:0] d);
      begin
         @(negedge clk_i);
         chip_select_n_o        = sel_n;
         register_select_line_o = rs;
         read_write_o           = rw;
         access_strobe_o        = 1'b1;
         data_o                 = d;
         @(negedge clk_i);
         rdata_q                = data_i;
         chip_select_n_o        = 1'b1;
         access_strobe_o        = 1'b0;
         data_o                 = ~d;
      end
   endtask

   // Start-up sequence: status read, control writes through both banks, status read
   task soft_reset;
      begin
         acc(1'b0, 1'b1, 1'b1, 4'h0);
         acc(1'b0, 1'b1, 1'b0, 4'h0);
         acc(1'b0, 1'b1, 1'b0, 4'h0);
         acc(1'b0, 1'b1, 1'b0, 4'h8);
         acc(1'b0, 1'b1, 1'b0, 4'h0);
         acc(1'b0, 1'b1, 1'b1, 4'h0);
      end
   endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
   localparam [21:0] BC = 22'h32;
   reg        clk_i;
   reg        rstn_i;
   reg        tone_present_i;
   reg  [3:0] decoded_code_i;
   reg        progress_square_i;
   wire       cs_n_w, rs_w, rw_w, stb_w, oe_w, steer_w, pin_w, pin_oe_n_w, ten_w, lo_w, hi_w, early_w;
   wire [3:0] wdata_w;
   wire [3:0] rdata_w;
   wire [3:0] rxc_w;
   wire [4:0] lo_ph_w;
   wire [4:0] hi_ph_w;
   wire       irq_line_w = pin_oe_n_w ? 1'b1 : pin_w;
   int        mismatches;
   int        checks;
   int        n;
   int        k2;
   logic [1:0] pat;

   dtmf_transceiver_host_registers #(.GUARD_PRESENT_CYC(22'h14), .GUARD_ABSENT_CYC(22'h14), .BURST_CYC(BC)) DUT (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .chip_select_n_i(cs_n_w), .register_select_line_i(rs_w),
      .read_write_i(rw_w), .access_strobe_i(stb_w), .data_i(wdata_w), .data_q_o(rdata_w), .data_oe_n_o(oe_w),
      .tone_present_i(tone_present_i), .decoded_code_i(decoded_code_i), .progress_square_i(progress_square_i),
      .early_detect_out_o(early_w), .delayed_steer_n_o(steer_w), .received_code_bits_o(rxc_w),
      .request_or_progress_pin_o(pin_w), .request_or_progress_pin_oe_n_o(pin_oe_n_w), .tone_output_enable_o(ten_w),
      .tone_low_on_o(lo_w), .tone_high_on_o(hi_w), .tone_low_phase_o(lo_ph_w), .tone_high_phase_o(hi_ph_w));

   // Released data lines show the inverse, so a read outside the drive window cannot pass
   host_cpu_model host (.clk_i(clk_i), .chip_select_n_o(cs_n_w), .register_select_line_o(rs_w),
      .read_write_o(rw_w), .access_strobe_o(stb_w), .data_o(wdata_w), .data_i(oe_w ? ~rdata_w : rdata_w));

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task wrap_up;
      if (mismatches == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // A wait that runs past its bound ends the run as a failure
   task limit(input int k, input int lim);
      if (k > lim) begin
         mismatches++;
         wrap_up;
      end
   endtask

   task cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask

   task tone(input [3:0] c, input int on, input int off);
      decoded_code_i = c;
      tone_present_i = 1'b1;
      cyc(on);
      tone_present_i = 1'b0;
      cyc(off);
   endtask

   task rd(input rs);
      host.acc(1'b0, rs, 1'b1, 4'h0);
   endtask

   task wr(input rs, input [3:0] d);
      host.acc(1'b0, rs, 1'b0, d);
   endtask

   // Length of one burst and which groups sounded in it
   task burst_len(output int k, output logic [1:0] p);
      k = 0;
      n = 0;
      while ((lo_w | hi_w) !== 1'b1) begin
         n++;
         limit(n, 4);
         @(negedge clk_i);
      end
      p = {lo_w, hi_w};
      while ((lo_w | hi_w) === 1'b1) begin
         k++;
         limit(k, 400);
         @(negedge clk_i);
      end
   endtask

   // Poll status until the transmitter reports ready
   task wait_ready;
      n = 0;
      rd(1'b1);
      while (host.rdata_q[1] !== 1'b1) begin
         n++;
         limit(n, 200);
         rd(1'b1);
      end
   endtask

   initial begin
      rstn_i = 1'b0;
      tone_present_i = 1'b0;
      decoded_code_i = 4'h0;
      progress_square_i = 1'b1;
      mismatches = 0;
      checks = 0;
      cyc(10);
      rstn_i = 1'b1;
      host.soft_reset;
      // Reset state, then a strobe while deselected must be ignored
      rd(1'b0);
      chk("rx code reset", host.rdata_q, 8'h00);
      chk("steer idle", steer_w, 8'h01);
      host.acc(1'b1, 1'b1, 1'b0, 4'h1);
      chk("deselected write", ten_w, 8'h00);
      // Bank select diverts exactly one control write
      wr(1'b1, 4'h9);
      chk("tone enable", ten_w, 8'h01);
      wr(1'b1, 4'h0);
      chk("second bank write", ten_w, 8'h01);
      wr(1'b1, 4'h0);
      chk("back to first", ten_w, 8'h00);
      // Receive: short tone rejected, valid tone with a tolerated dropout
      wr(1'b1, 4'h4);
      tone(4'h7, 10, 25);
      rd(1'b0);
      chk("short tone", host.rdata_q, 8'h00);
      tone(4'h7, 25, 5);
      chk("dropout steer", steer_w, 8'h00);
      chk("rx request", irq_line_w, 8'h00);
      tone(4'h7, 5, 30);
      chk("tone end steer", steer_w, 8'h01);
      rd(1'b0);
      chk("rx kept", host.rdata_q, 8'h07);
      chk("rx pins", rxc_w, 8'h07);
      rd(1'b1);
      chk("status valid", host.rdata_q & 4'h5, 8'h05);
      chk("request cleared", irq_line_w, 8'h01);
      rd(1'b1);
      chk("status cleared", host.rdata_q & 4'h5, 8'h00);
      // Progress mode: no decoding, pin shows the comparator
      wr(1'b1, 4'h6);
      progress_square_i = 1'b0;
      decoded_code_i = 4'h3;
      tone_present_i = 1'b1;
      cyc(25);
      chk("early off", early_w, 8'h00);
      chk("no steer", steer_w, 8'h01);
      chk("square low", irq_line_w, 8'h00);
      progress_square_i = 1'b1;
      tone_present_i = 1'b0;
      cyc(1);
      chk("square high", irq_line_w, 8'h01);
      // Burst in tone mode, then the pause ending in a ready request
      wr(1'b1, 4'h5);
      rd(1'b1);
      wr(1'b0, 4'h1);
      burst_len(n, pat);
      chk("pair", pat, 8'h03);
      chk("burst", n[7:0], BC[7:0]);
      n = 0;
      while (irq_line_w !== 1'b0) begin
         n++;
         limit(n, 200);
         @(negedge clk_i);
      end
      chk("pause", (n >= 48 && n <= 52), 8'h01);
      rd(1'b1);
      chk("ready", host.rdata_q & 4'h2, 8'h02);
      // Progress mode doubles the burst
      wr(1'b1, 4'h7);
      wr(1'b0, 4'h2);
      burst_len(n, pat);
      chk("long burst", n[7:0], 8'h64);
      wait_ready;
      // Single high-group tone
      wr(1'b1, 4'hD);
      wr(1'b1, 4'hC);
      wr(1'b0, 4'h5);
      burst_len(n, pat);
      chk("single high", pat, 8'h01);
      // Free-running dual tone: first segment of each group against 699.1 Hz and 1215.9 Hz over 32 segments
      wr(1'b0, 4'h1);
      wr(1'b1, 4'h9);
      wr(1'b1, 4'h1);
      n = 0;
      k2 = 0;
      while (lo_ph_w !== 5'h01) begin
         n++;
         if (hi_ph_w === 5'h00) k2 = n;
         limit(n, 2000);
         @(negedge clk_i);
      end
      chk("low segment", (n >= 1770 && n <= 1805), 8'h01);
      chk("high segment", (k2 >= 1015 && k2 <= 1040), 8'h01);
      wrap_up;
   end
endmodule
